// File: owd_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
`include "owd_params.svh"
module owd_watchdog
   import owd_pkg::*;
(
   // clock and reset
   input  wire logic        MCLK_IN,
   input  wire logic        RESET_N_IN,
   // register port
   input  wire logic [7:0]  ADDR_IN,
   input  wire logic [31:0] WDATA_IN,
   input  wire logic        WR_IN,
   input  wire logic        RD_IN,
   output var  logic [31:0] RDATA_OUT,
   // system state
   input  wire logic        STOP_MODE_IN,
   input  wire logic        DEBUG_MODE_IN,
   input  wire logic        EXT_RESET_N_IN,
   // outputs
   output var  logic        SYS_RESET_OUT,
   output var  logic        IRQ_OUT
);
   localparam int unsigned PULSE = `OWD_RST_PULSE_CYC;

   owd_tick_if tk ();

   logic        opt1_en_reg;
   logic        opt1_tmo_reg;
   logic        opt2_clk_reg;
   logic        opt1_lock_reg;
   logic        opt2_lock_reg;
   owd_count_t  count_reg;
   logic        cause_wd_reg;
   logic        cause_ext_reg;
   logic [1:0]  status_reg;
   logic [1:0]  mask_reg;
   owd_state_e  state_reg;
   logic [4:0]  pulse_reg;
   logic        stop_s1_reg;
   logic        stop_s2_reg;
   logic        stop_d_reg;
   logic        dbg_s1_reg;
   logic        dbg_s2_reg;
   logic        ext_s1_reg;
   logic        ext_s2_reg;
   logic        ext_seen_reg;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction : hit

   logic        wr_opt1;
   logic        wr_opt2;
   logic        wr_svc;
   logic        wr_status;
   logic        wr_mask;
   logic        first_opt1;
   logic        first_opt2;
   logic        svc_clear;
   logic        stop_enter;
   logic        step;
   logic        overflow;
   logic [1:0]  status_set;
   logic [31:0] rd_word;
   owd_count_t  limit;

   assign wr_opt1    = WR_IN && hit(ADDR_IN, `OWD_ADDR_OPT1);
   assign wr_opt2    = WR_IN && hit(ADDR_IN, `OWD_ADDR_OPT2);
   assign wr_svc     = WR_IN && hit(ADDR_IN, `OWD_ADDR_CAUSE);
   assign wr_status  = WR_IN && hit(ADDR_IN, `OWD_ADDR_STATUS);
   assign wr_mask    = WR_IN && hit(ADDR_IN, `OWD_ADDR_MASK);
   assign first_opt1 = wr_opt1 && !opt1_lock_reg;
   assign first_opt2 = wr_opt2 && !opt2_lock_reg;
   assign svc_clear  = wr_svc || first_opt1 || first_opt2;
   assign stop_enter = stop_s2_reg && !stop_d_reg;
   assign status_set = {first_opt1 || first_opt2, wr_svc};

   // two-flop synchronisers for pin-level inputs; stop keeps a delayed copy for entry
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         stop_s1_reg <= 1'b0;
         stop_s2_reg <= 1'b0;
         stop_d_reg  <= 1'b0;
      end else begin
         stop_s1_reg <= STOP_MODE_IN;
         stop_s2_reg <= stop_s1_reg;
         stop_d_reg  <= stop_s2_reg;
      end
   end

   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         dbg_s1_reg <= 1'b0;
         dbg_s2_reg <= 1'b0;
      end else begin
         dbg_s1_reg <= DEBUG_MODE_IN;
         dbg_s2_reg <= dbg_s1_reg;
      end
   end

   // pin idles high; resetting high avoids a false edge
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ext_s1_reg <= 1'b1;
         ext_s2_reg <= 1'b1;
      end else begin
         ext_s1_reg <= EXT_RESET_N_IN;
         ext_s2_reg <= ext_s1_reg;
      end
   end

   // slow tick restarts while stopped so count resumes from zero
   assign tk.restart = stop_s2_reg;

   // ~1 kHz tick enable
   owd_lf_tick u_lf_tick (
      .clk_in   (MCLK_IN),
      .rst_n_in (RESET_N_IN),
      .tk       (tk)
   );

   // option registers, write-once after reset
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         opt1_en_reg   <= 1'b1;
         opt1_tmo_reg  <= 1'b1;
         opt1_lock_reg <= 1'b0;
      end else if (first_opt1) begin
         opt1_en_reg   <= WDATA_IN[`OWD_OPT1_EN_BIT];
         opt1_tmo_reg  <= WDATA_IN[`OWD_OPT1_TMO_BIT];
         opt1_lock_reg <= 1'b1;
      end
   end

   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         opt2_clk_reg  <= 1'b1;
         opt2_lock_reg <= 1'b0;
      end else if (first_opt2) begin
         opt2_clk_reg  <= WDATA_IN[`OWD_OPT2_CLK_BIT];
         opt2_lock_reg <= 1'b1;
      end
   end

   // last count before overflow; worked in 19 bits since 2^18 does not fit
   always_comb begin
      case ({opt2_clk_reg, opt1_tmo_reg})
         2'b00:   limit = owd_count_t'((19'h0_0001 << `OWD_LF_SHORT_LOG2) - 19'h0_0001);
         2'b01:   limit = owd_count_t'((19'h0_0001 << `OWD_LF_LONG_LOG2) - 19'h0_0001);
         2'b10:   limit = owd_count_t'((19'h0_0001 << `OWD_BUS_SHORT_LOG2) - 19'h0_0001);
         default: limit = owd_count_t'((19'h0_0001 << `OWD_BUS_LONG_LOG2) - 19'h0_0001);
      endcase
   end

   // bus clock counts every cycle, slow clock on tick
   assign step = opt1_en_reg && !dbg_s2_reg && !stop_s2_reg
                 && (opt2_clk_reg || tk.tick);
   assign overflow = step && (count_reg == limit);

   // watchdog counter
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         count_reg <= '0;
      end else if (state_reg != OWD_RUN || svc_clear) begin
         count_reg <= '0;
      end else if (stop_enter && !opt2_clk_reg) begin
         count_reg <= '0;
      end else if (overflow) begin
         count_reg <= '0;
      end else if (step) begin
         count_reg <= count_reg + owd_count_t'(1);
      end
   end

   // reset pulse sequencer
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         state_reg <= OWD_RUN;
         pulse_reg <= 5'h00;
      end else begin
         case (state_reg)
            OWD_RUN: begin
               if (overflow) begin
                  state_reg <= OWD_FIRE;
                  pulse_reg <= 5'h00;
               end
            end
            OWD_FIRE: begin
               if (pulse_reg == 5'(PULSE - 1)) begin
                  state_reg <= OWD_HOLD;
               end else begin
                  pulse_reg <= pulse_reg + 5'h01;
               end
            end
            default: begin
               state_reg <= OWD_RUN;
            end
         endcase
      end
   end

   // reset output high for the whole fire state
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         SYS_RESET_OUT <= 1'b0;
      end else if (state_reg == OWD_RUN) begin
         SYS_RESET_OUT <= overflow;
      end else if (state_reg == OWD_FIRE) begin
         SYS_RESET_OUT <= (pulse_reg != 5'(PULSE - 1));
      end else begin
         SYS_RESET_OUT <= 1'b0;
      end
   end

   // reset cause; survives own system reset pulse
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         cause_wd_reg  <= 1'b0;
         cause_ext_reg <= 1'b0;
         ext_seen_reg  <= 1'b0;
      end else begin
         ext_seen_reg <= !ext_s2_reg;
         if (overflow && state_reg == OWD_RUN) begin
            cause_wd_reg  <= 1'b1;
            cause_ext_reg <= 1'b0;
         end else if (!ext_s2_reg && !ext_seen_reg) begin
            cause_wd_reg  <= 1'b0;
            cause_ext_reg <= 1'b1;
         end
      end
   end

   // sticky events: service and lock; set wins over clear
   generate
      for (genvar i = 0; i < 2; i++) begin : g_status
         always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
            if (!RESET_N_IN) begin
               status_reg[i] <= 1'b0;
            end else if (status_set[i]) begin
               status_reg[i] <= 1'b1;
            end else if (wr_status && WDATA_IN[i]) begin
               status_reg[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // interrupt mask, same layout as status
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         mask_reg <= 2'b00;
      end else if (wr_mask) begin
         mask_reg <= WDATA_IN[1:0];
      end
   end

   // level interrupt, one cycle behind status
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         IRQ_OUT <= 1'b0;
      end else begin
         IRQ_OUT <= |(status_reg & mask_reg);
      end
   end

   // read mux; cause register is read-only
   always_comb begin
      rd_word = 32'h0000_0000;
      case (ADDR_IN)
         `OWD_ADDR_OPT1:   rd_word = {24'h0, opt1_en_reg, opt1_tmo_reg, 6'h00};
         `OWD_ADDR_OPT2:   rd_word = {24'h0, opt2_clk_reg, 7'h00};
         `OWD_ADDR_CAUSE:  rd_word = {24'h0, 1'b0, cause_ext_reg, cause_wd_reg, 5'h00};
         `OWD_ADDR_STATUS: rd_word = {30'h0, status_reg};
         `OWD_ADDR_MASK:   rd_word = {30'h0, mask_reg};
         `OWD_ADDR_COUNT:  rd_word = {14'h0, count_reg};
         default:          rd_word = 32'h0000_0000;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         RDATA_OUT <= 32'h0000_0000;
      end else if (RD_IN) begin
         RDATA_OUT <= rd_word;
      end else begin
         RDATA_OUT <= 32'h0000_0000;
      end
   end
endmodule : owd_watchdog
`default_nettype wire

// File: owd_params.svh
`ifndef OWD_PARAMS_SVH
`define OWD_PARAMS_SVH

// register offsets (byte addresses, 32-bit words)
`define OWD_ADDR_OPT1      8'h00
`define OWD_ADDR_OPT2      8'h04
`define OWD_ADDR_CAUSE     8'h08
`define OWD_ADDR_STATUS    8'h0c
`define OWD_ADDR_MASK      8'h10
`define OWD_ADDR_COUNT     8'h14

// field positions
`define OWD_OPT1_EN_BIT    7
`define OWD_OPT1_TMO_BIT   6
`define OWD_OPT2_CLK_BIT   7
`define OWD_CAUSE_WD_BIT   5
`define OWD_CAUSE_EXT_BIT  6
`define OWD_IRQ_SVC_BIT    0
`define OWD_IRQ_LOCK_BIT   1

// reset values
`define OWD_OPT1_RESET     8'hc0
`define OWD_OPT2_RESET     8'h80

// overflow counts (log2)
`define OWD_LF_SHORT_LOG2  5
`define OWD_LF_LONG_LOG2   8
`define OWD_BUS_SHORT_LOG2 13
`define OWD_BUS_LONG_LOG2  18

// low-frequency tick period
`define OWD_LF_PERIOD_US   1000
`define OWD_CLK_NS         100
`define OWD_LF_DIV_CYCLES  ((`OWD_LF_PERIOD_US * 1000) / `OWD_CLK_NS)

// width of the system reset pulse
`define OWD_RST_PULSE_CYC  16

`endif

// File: owd_pkg.sv
package owd_pkg;
   typedef logic [17:0] owd_count_t;
   typedef enum logic [1:0] {
      OWD_RUN   = 2'b00,
      OWD_FIRE  = 2'b01,
      OWD_HOLD  = 2'b10
   } owd_state_e;
endpackage : owd_pkg

// File: owd_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface owd_tick_if;
   logic tick;
   logic restart;
   modport src (output tick, input restart);
   modport dst (input tick, output restart);
endinterface : owd_tick_if
`default_nettype wire

// File: owd_lf_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "owd_params.svh"
module owd_lf_tick
   import owd_pkg::*;
(
   input wire logic  clk_in,
   input wire logic  rst_n_in,
   owd_tick_if.src   tk
);
   localparam int unsigned DIV = `OWD_LF_DIV_CYCLES;
   logic [13:0] div_reg;

   // ~1 kHz enable; restart realigns after stop
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_reg <= 14'h0000;
         tk.tick <= 1'b0;
      end else if (tk.restart) begin
         div_reg <= 14'h0000;
         tk.tick <= 1'b0;
      end else if (div_reg == 14'(DIV - 1)) begin
         div_reg <= 14'h0000;
         tk.tick <= 1'b1;
      end else begin
         div_reg <= div_reg + 14'h0001;
         tk.tick <= 1'b0;
      end
   end
endmodule : owd_lf_tick
`default_nettype wire

// File: owd_wd_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "owd_params.svh"
module owd_wd_chk
   import owd_pkg::*;
(
   // clock and bus
   input wire logic        MCLK_IN,
   input wire logic        RESET_N_IN,
   input wire logic [7:0]  ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic        WR_IN,
   input wire logic        RD_IN,
   input wire logic [31:0] RDATA_OUT,
   // modes and outputs
   input wire logic        STOP_MODE_IN,
   input wire logic        DEBUG_MODE_IN,
   input wire logic        SYS_RESET_OUT,
   input wire logic        IRQ_OUT
);
   logic [4:0] hi_reg;
   logic       seen_reg;
   logic       fired_reg;
   logic [1:0] opt_reg;
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (!RESET_N_IN);
   // pulse length, lock state and fire history
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         hi_reg    <= 5'h0;
         seen_reg  <= 1'b0;
         fired_reg <= 1'b0;
         opt_reg   <= 2'h3;
      end else begin
         hi_reg <= SYS_RESET_OUT ? hi_reg + 5'h1 : 5'h0;
         fired_reg <= fired_reg | SYS_RESET_OUT;
         if (WR_IN && ADDR_IN == `OWD_ADDR_OPT1 && !seen_reg) begin
            seen_reg <= 1'b1;
            opt_reg  <= WDATA_IN[7:6];
         end
      end
   end
   a_opt_lock:
      assert property (RD_IN && ADDR_IN == `OWD_ADDR_OPT1 |=> RDATA_OUT[7:6] == opt_reg)
      else $error("option bits differ from first write");
   a_cause_wd:
      assert property (RD_IN && ADDR_IN == `OWD_ADDR_CAUSE && fired_reg |=> RDATA_OUT[5])
      else $error("watchdog cause bit not set");
   a_count_width:
      assert property (RD_IN && ADDR_IN == `OWD_ADDR_COUNT |=> RDATA_OUT[31:18] == 14'h0)
      else $error("count wider than 18 bits");
   a_pulse_len:
      assert property ($fell(SYS_RESET_OUT) |-> hi_reg == 5'h10)
      else $error("reset pulse not 16 cycles");
   a_pulse_max:
      assert property (hi_reg <= 5'h10)
      else $error("reset pulse too long");
   a_pulse_gap:
      assert property ($fell(SYS_RESET_OUT) |-> !SYS_RESET_OUT [*8])
      else $error("reset pulse repeats too soon");
   a_debug_hold:
      assert property (DEBUG_MODE_IN [*6] |-> !$rose(SYS_RESET_OUT))
      else $error("overflow while in debug");
   a_stop_hold:
      assert property (STOP_MODE_IN [*6] |-> !$rose(SYS_RESET_OUT))
      else $error("overflow while in stop");
   a_irq_masked:
      assert property (WR_IN && ADDR_IN == `OWD_ADDR_MASK && WDATA_IN == 32'h0 ##1 !WR_IN
                       |=> !IRQ_OUT)
      else $error("interrupt high with all masked");
endmodule : owd_wd_chk
bind owd_watchdog owd_wd_chk u_chk (
   .MCLK_IN       (MCLK_IN),
   .RESET_N_IN    (RESET_N_IN),
   .ADDR_IN       (ADDR_IN),
   .WDATA_IN      (WDATA_IN),
   .WR_IN         (WR_IN),
   .RD_IN         (RD_IN),
   .RDATA_OUT     (RDATA_OUT),
   .STOP_MODE_IN  (STOP_MODE_IN),
   .DEBUG_MODE_IN (DEBUG_MODE_IN),
   .SYS_RESET_OUT (SYS_RESET_OUT),
   .IRQ_OUT       (IRQ_OUT)
);
`default_nettype wire

// File: watchdog_timeout_reset_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "owd_params.svh"
`define CHK(g, e) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("mismatch at %0t got %h exp %h", $time, (g), (e)); \
   end \
end
module watchdog_timeout_reset_tb
   import owd_pkg::*;
;
   logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, stop = 1'b0, dbg = 1'b0;
   logic        ext_n = 1'b1;
   logic [7:0]  addr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, d, c;
   logic        sys_rst, irq;
   int          n_mismatch = 0, checks_done = 0, hi_cyc = 0, n;
   always #50 clk = ~clk;
   always @(posedge clk) if (sys_rst === 1'b1) hi_cyc++;
   owd_watchdog dut (.MCLK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
      .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .STOP_MODE_IN(stop), .DEBUG_MODE_IN(dbg),
      .EXT_RESET_N_IN(ext_n), .SYS_RESET_OUT(sys_rst), .IRQ_OUT(irq));
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic wait_cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : wait_cyc
   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      wait_cyc(12);
      rst_n <= 1'b1;
   endtask : do_reset
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   initial begin
      do_reset();
      wait_cyc(40);
      rd_reg(`OWD_ADDR_OPT1, d);
      `CHK(d[7:6], 2'h3)
      rd_reg(`OWD_ADDR_OPT2, d);
      `CHK(d[7], 1'b1)
      rd_reg(8'hfc, d);
      `CHK(d, 32'h0)
      wr_reg(`OWD_ADDR_OPT1, 32'h80);
      rd_reg(`OWD_ADDR_COUNT, d);
      `CHK(d < 32'h8, 1'b1)
      wr_reg(`OWD_ADDR_OPT1, 32'h0);
      wr_reg(`OWD_ADDR_OPT2, 32'h80);
      wr_reg(`OWD_ADDR_OPT2, 32'h0);
      rd_reg(`OWD_ADDR_OPT1, d);
      `CHK(d[7:6], 2'h2)
      rd_reg(`OWD_ADDR_OPT2, d);
      `CHK(d[7], 1'b1)
      // interrupt raise, mask, clear
      wr_reg(`OWD_ADDR_MASK, 32'h2);
      wait_cyc(2);
      #1 `CHK(irq, 1'b1)
      wr_reg(`OWD_ADDR_MASK, 32'h0);
      wait_cyc(2);
      #1 `CHK(irq, 1'b0)
      wr_reg(`OWD_ADDR_MASK, 32'h3);
      wr_reg(`OWD_ADDR_STATUS, 32'h3);
      wait_cyc(2);
      #1 `CHK(irq, 1'b0)
      for (n = 0; n < 3; n++) begin
         wait_cyc(6000);
         wr_reg(`OWD_ADDR_CAUSE, 32'hff);
      end
      rd_reg(`OWD_ADDR_CAUSE, d);
      `CHK(d, 32'h0)
      `CHK(hi_cyc, 0)
      `CHK(irq, 1'b1)
      for (n = 0; n < 2; n++) begin
         @(posedge clk);
         dbg  <= (n == 0);
         stop <= (n == 1);
         wait_cyc(5);
         rd_reg(`OWD_ADDR_COUNT, c);
         wait_cyc(20);
         rd_reg(`OWD_ADDR_COUNT, d);
         `CHK(d, c)
         @(posedge clk);
         dbg  <= 1'b0;
         stop <= 1'b0;
         wait_cyc(5);
         rd_reg(`OWD_ADDR_COUNT, d);
         `CHK(d > c, 1'b1)
      end
      wr_reg(`OWD_ADDR_CAUSE, 32'h0);
      n = 0;
      while (sys_rst !== 1'b1 && n < 9000) begin
         @(posedge clk);
         #1 n++;
      end
      `CHK(n > 8189 && n < 8198, 1'b1)
      wait_cyc(20);
      `CHK(hi_cyc, 16)
      rd_reg(`OWD_ADDR_CAUSE, d);
      `CHK(d[5], 1'b1)
      // slow clock after a fresh reset
      do_reset();
      wr_reg(`OWD_ADDR_OPT1, 32'hc0);
      wr_reg(`OWD_ADDR_OPT2, 32'h0);
      wait_cyc(25000);
      rd_reg(`OWD_ADDR_COUNT, d);
      `CHK(d > 0 && d < 4, 1'b1)
      @(posedge clk);
      stop <= 1'b1;
      wait_cyc(5);
      rd_reg(`OWD_ADDR_COUNT, d);
      `CHK(d, 32'h0)
      // external pin low records its own cause
      @(posedge clk);
      ext_n <= 1'b0;
      wait_cyc(4);
      ext_n <= 1'b1;
      wait_cyc(4);
      rd_reg(`OWD_ADDR_CAUSE, d);
      `CHK(d, 32'h40)
      complete_run();
   end
   initial begin
      #8000000;
      n_mismatch++;
      complete_run();
   end
endmodule : watchdog_timeout_reset_tb
`default_nettype wire
